/* File: chic_top.sv */
// Host interface control, clocking, fast read buffer and standard mask.
//
// Contract
// - Control register reads E1 in reset, 61 after.
// - Reset flag set; only control reads accepted.
// - System clock halves doubled clock or oscillator.
// - Memory clock equals or halves system clock.
// - Decode power-down and sleep bits into modes.
// - Bus activity clears sleep bit while sleeping.
// - Pin select routes interrupt, floats dedicated pin.
// - Stretch stops clock output during slow accesses.
// - Clock output driven only when enabled.
// - Control register accessible in any power mode.
// - Doubled clock feeds system clock for protocol unless halved; the oscillator feeds it then.
// - Clock output from doubled clock, divider set.
// - Doubler stops when unused, stretched and halved.
// - Slow reads load fast buffer; reset keeps it.
// - Word read fills both bytes, byte read low.
// - Standard mask bits select must-match identifier bits.
// - Mask reserved bits read ones; reset keeps mask.
// - Remote answer uses the object's own identifier.
// - Wake flag on activity, sleep clear, power-up.
`timescale 1ns/10ps
`default_nettype none
module chic_top
    import chic_pkg::*;
(
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Host register port
    input wire logic [7:0] i_host_addr,
    input wire logic i_host_rd,
    input wire logic i_host_wr,
    input wire logic i_host_word,
    input wire logic [15:0] i_host_wdata,
    output logic [15:0] o_host_rdata,
    output logic o_host_rvalid,
    output logic o_host_busy,
    output logic o_host_wait,
    // Low-speed register memory and clock-output divider
    output logic o_ram_req,
    output logic o_ram_we,
    output logic o_ram_word,
    output logic [7:0] o_ram_addr,
    output logic [15:0] o_ram_wdata,
    input wire logic i_ram_ack,
    input wire logic [15:0] i_ram_rdata,
    input wire logic [3:0] i_clkout_divider,
    // Clocks and power
    output logic o_sclk_en,
    output logic o_mclk_en,
    output logic o_pll_run,
    output logic o_clkout,
    output logic o_clkout_oe_n,
    output logic o_mode_sleep,
    output logic o_mode_pd,
    output logic o_wakeup,
    input wire logic i_can_activity,
    // Interrupt and port pins
    input wire logic i_irq,
    input wire logic i_p26_out,
    input wire logic i_p26_oe_n,
    output logic o_int_n,
    output logic o_int_oe_n,
    output logic o_p26,
    output logic o_p26_oe_n,
    // Acceptance filtering
    input wire logic [10:0] i_rx_id,
    input wire logic [10:0] i_obj_id,
    input wire logic i_obj_xtd,
    input wire logic i_remote_hit,
    output logic o_std_match,
    output logic [10:0] o_tx_id
);
    function automatic logic id_match(input logic [10:0] a,
                                      input logic [10:0] b,
                                      input logic [10:0] m);
        id_match = ((a ^ b) & m) == 11'h000;
    endfunction

    chic_clk_if ck ();
    chic_clkgen #(.DIV_W(4)) u_clkgen (
        .i_core_clk(i_core_clk),
        .i_reset_n(i_reset_n),
        .c(ck)
    );

    chic_state_t st_r, st_nxt;
    logic flag_r, flag_nxt;
    logic [6:0] icr_r, icr_nxt;
    logic [15:0] rd_r, rd_nxt, frb_r, frb_nxt;
    logic rv_r, rv_nxt, wk_r, wk_nxt, pll_r, pll_nxt;
    logic req_r, req_nxt, we_r, we_nxt, wd_r, wd_nxt;
    logic [7:0] ra_r, ra_nxt;
    logic [15:0] rwd_r, rwd_nxt;
    logic [10:0] msk_r, msk_nxt;
    logic s1_r, s2_r, s3_r;
    logic act, fast, acc, sl, pd;
    logic pins_nxt [0:7];
    logic [7:0] pin_r;
    logic match_r, match_nxt;
    logic [10:0] txid_r, txid_nxt;

    always_comb
    begin
        fast = (i_host_addr == OFS_ICR) || (i_host_addr == OFS_FRB_LO)
            || (i_host_addr == OFS_FRB_HI) || (i_host_addr == OFS_MSK_LO)
            || (i_host_addr == OFS_MSK_HI);
        // Only control reads pass while the reset flag is up.
        acc = (i_host_rd | i_host_wr) && st_r == ST_IDLE
            && (!flag_r || (i_host_rd && i_host_addr == OFS_ICR));
        act = s2_r & ~s3_r;
        sl = icr_r[BIT_SLEEP];
        pd = icr_r[BIT_PD];
        st_nxt = st_r;
        flag_nxt = 1'b0;
        icr_nxt = icr_r;
        rd_nxt = rd_r;
        rv_nxt = 1'b0;
        wk_nxt = 1'b0;
        frb_nxt = frb_r;
        msk_nxt = msk_r;
        req_nxt = 1'b0;
        we_nxt = we_r;
        wd_nxt = wd_r;
        ra_nxt = ra_r;
        rwd_nxt = rwd_r;
        // Hardware clears sleep on bus activity; a host write wins.
        if (act && sl && !pd)
        begin
            icr_nxt[BIT_SLEEP] = 1'b0;
            wk_nxt = 1'b1;
        end
        if (acc && fast && i_host_wr)
        begin
            if (i_host_addr == OFS_ICR)
            begin
                icr_nxt = i_host_wdata[6:0];
                wk_nxt = wk_nxt | (sl & ~pd & ~i_host_wdata[BIT_SLEEP])
                    | (pd & ~i_host_wdata[BIT_PD]);
            end
            if (i_host_addr == OFS_MSK_LO)
            begin
                msk_nxt[10:3] = i_host_wdata[7:0];
                if (i_host_word)
                begin
                    msk_nxt[2:0] = i_host_wdata[15:13];
                end
            end
            if (i_host_addr == OFS_MSK_HI)
            begin
                msk_nxt[2:0] = i_host_wdata[7:5];
            end
        end
        if (acc && fast && i_host_rd)
        begin
            rv_nxt = 1'b1;
            case (i_host_addr)
                OFS_ICR: rd_nxt = {8'h00, flag_r, icr_r};
                OFS_FRB_LO: rd_nxt = i_host_word ? frb_r : {8'h00, frb_r[7:0]};
                OFS_FRB_HI: rd_nxt = {8'h00, frb_r[15:8]};
                OFS_MSK_LO: rd_nxt = i_host_word
                    ? {msk_r[2:0], MSK_RES_ONES, msk_r[10:3]}
                    : {8'h00, msk_r[10:3]};
                default: rd_nxt = {8'h00, msk_r[2:0], MSK_RES_ONES};
            endcase
        end
        case (st_r)
            ST_IDLE:
            begin
                if (acc && !fast)
                begin
                    st_nxt = ST_RAM;
                    req_nxt = 1'b1;
                    we_nxt = i_host_wr;
                    wd_nxt = i_host_word;
                    ra_nxt = i_host_addr;
                    rwd_nxt = i_host_wdata;
                end
            end
            ST_RAM:
            begin
                if (i_ram_ack)
                begin
                    st_nxt = ST_IDLE;
                    if (!we_r)
                    begin
                        rv_nxt = 1'b1;
                        rd_nxt = wd_r ? i_ram_rdata : {8'h00, i_ram_rdata[7:0]};
                        frb_nxt[7:0] = i_ram_rdata[7:0];
                        if (wd_r)
                        begin
                            frb_nxt[15:8] = i_ram_rdata[15:8];
                        end
                    end
                end
            end
            default: st_nxt = ST_IDLE;
        endcase
        // Doubler stops when clock output unused, stretch set and system clock halved.
        pll_nxt = ~icr_nxt[BIT_PD] & ~(icr_nxt[BIT_SYSH]
            & icr_nxt[BIT_STR] & ~icr_nxt[BIT_CKON]);
        pins_nxt[0] = ~i_irq;
        pins_nxt[1] = icr_r[BIT_MUX];
        pins_nxt[2] = icr_r[BIT_MUX] ? ~i_irq : i_p26_out;
        pins_nxt[3] = icr_r[BIT_MUX] ? 1'b0 : i_p26_oe_n;
        pins_nxt[4] = ~icr_r[BIT_CKON];
        pins_nxt[5] = ~pd & sl;
        pins_nxt[6] = (st_nxt == ST_RAM);
        pins_nxt[7] = (st_nxt == ST_RAM) & ~icr_nxt[BIT_STR];
        match_nxt = ~i_obj_xtd & id_match(i_rx_id, i_obj_id, msk_r);
        txid_nxt = i_remote_hit ? i_obj_id : txid_r;
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            st_r <= ST_IDLE;
            flag_r <= 1'b1;
            icr_r <= ICR_RESET;
            rd_r <= {8'h00, ICR_IN_RESET};
            rv_r <= 1'b0;
            wk_r <= 1'b0;
            pll_r <= 1'b1;
            req_r <= 1'b0;
            we_r <= 1'b0;
            wd_r <= 1'b0;
            ra_r <= 8'h00;
            rwd_r <= 16'h0000;
            s1_r <= 1'b0;
            s2_r <= 1'b0;
            s3_r <= 1'b0;
            pin_r <= 8'h13;
            match_r <= 1'b0;
            txid_r <= 11'h000;
        end
        else
        begin
            st_r <= st_nxt;
            flag_r <= flag_nxt;
            icr_r <= icr_nxt;
            rd_r <= rd_nxt;
            rv_r <= rv_nxt;
            wk_r <= wk_nxt;
            pll_r <= pll_nxt;
            req_r <= req_nxt;
            we_r <= we_nxt;
            wd_r <= wd_nxt;
            ra_r <= ra_nxt;
            rwd_r <= rwd_nxt;
            s1_r <= i_can_activity;
            s2_r <= s1_r;
            s3_r <= s2_r;
            pin_r <= {pins_nxt[7], pins_nxt[6], pins_nxt[5], pins_nxt[4],
                      pins_nxt[3], pins_nxt[2], pins_nxt[1], pins_nxt[0]};
            match_r <= match_nxt;
            txid_r <= txid_nxt;
        end
    end

    // Buffer and mask survive hardware reset.
    always_ff @(posedge i_core_clk)
    begin
        frb_r <= frb_nxt;
        msk_r <= msk_nxt;
    end

    assign ck.pll_run = pll_r;
    assign ck.osc_run = ~icr_r[BIT_PD];
    assign ck.sys_halve = icr_r[BIT_SYSH];
    assign ck.mem_halve = icr_r[BIT_MEMH];
    assign ck.stall = icr_r[BIT_STR] & (st_r == ST_RAM);
    assign ck.div = i_clkout_divider;
    assign o_sclk_en = ck.sclk_en;
    assign o_mclk_en = ck.mclk_en;
    assign o_clkout = ck.clkout;
    assign o_pll_run = pll_r;
    assign o_host_rdata = rd_r;
    assign o_host_rvalid = rv_r;
    assign o_host_busy = pin_r[6];
    assign o_host_wait = pin_r[7];
    assign o_ram_req = req_r;
    assign o_ram_we = we_r;
    assign o_ram_word = wd_r;
    assign o_ram_addr = ra_r;
    assign o_ram_wdata = rwd_r;
    assign o_wakeup = wk_r;
    assign o_int_n = pin_r[0];
    assign o_int_oe_n = pin_r[1];
    assign o_p26 = pin_r[2];
    assign o_p26_oe_n = pin_r[3];
    assign o_clkout_oe_n = pin_r[4];
    assign o_mode_sleep = pin_r[5];
    assign o_mode_pd = icr_r[BIT_PD];
    assign o_std_match = match_r;
    assign o_tx_id = txid_r;

    default clocking dc @(posedge i_core_clk); endclocking
    default disable iff (!i_reset_n);

    AST_FLAG_DROPS: assert property (flag_r |=> !flag_r)
        else $error("reset flag did not clear");
    AST_REFUSE: assert property (flag_r && i_host_rd
        && i_host_addr != OFS_ICR |=> !o_host_rvalid && !o_ram_req)
        else $error("access answered while reset flag set");
    AST_ICR_READ: assert property (i_host_rd && i_host_addr == OFS_ICR
        && st_r == ST_IDLE |=> o_host_rvalid
        && o_host_rdata[7:0] == {$past(flag_r), $past(icr_r)})
        else $error("control register read wrong");
    AST_SLEEP_WAKE: assert property (act && sl && !pd && !i_host_wr
        |=> !icr_r[BIT_SLEEP] && o_wakeup)
        else $error("bus activity did not wake");
    AST_PD_MODE: assert property (icr_r[BIT_PD] [*2] |-> o_mode_pd
        && !o_mode_sleep)
        else $error("power-down decode wrong");
    AST_MUX_FLOAT: assert property (icr_r[BIT_MUX] |=> o_int_oe_n
        && o_p26 == !$past(i_irq))
        else $error("interrupt routing wrong");
    AST_CKOUT_OFF: assert property (!icr_r[BIT_CKON] |=> o_clkout_oe_n)
        else $error("clock output driven while disabled");
    AST_STRETCH: assert property (ck.stall |=> $stable(o_clkout))
        else $error("clock output ran during stretch");
    AST_FRB_LOAD: assert property (st_r == ST_RAM && i_ram_ack && !we_r
        |=> frb_r[7:0] == $past(i_ram_rdata[7:0]))
        else $error("fast buffer not loaded");
    AST_PLL_STOP: assert property (icr_r[BIT_SYSH] && icr_r[BIT_STR]
        && !icr_r[BIT_CKON] && !i_host_wr |=> !o_pll_run)
        else $error("doubler not stopped");
    CV_DOUBLE_READ: cover property (st_r == ST_RAM && i_ram_ack && !we_r
        ##[1:20] i_host_rd && i_host_addr == OFS_FRB_LO);
    CV_WAKE: cover property (o_wakeup);
    CV_STALL: cover property (ck.stall [*3]);
endmodule // chic_top
`default_nettype wire

/* File: chic_pkg.sv */
// Constants shared by the host interface and clocking block.
package chic_pkg;
    localparam logic [7:0] OFS_ICR = 8'h02;
    localparam logic [7:0] OFS_FRB_LO = 8'h04;
    localparam logic [7:0] OFS_FRB_HI = 8'h05;
    localparam logic [7:0] OFS_MSK_LO = 8'h06;
    localparam logic [7:0] OFS_MSK_HI = 8'h07;
    localparam logic [7:0] OFS_CLKOUT = 8'h1f;
    localparam logic [7:0] ICR_IN_RESET = 8'he1;
    localparam logic [6:0] ICR_RESET = 7'h61;
    localparam int BIT_RSTF = 7;
    localparam int BIT_SYSH = 6;
    localparam int BIT_MEMH = 5;
    localparam int BIT_PD = 4;
    localparam int BIT_SLEEP = 3;
    localparam int BIT_MUX = 2;
    localparam int BIT_STR = 1;
    localparam int BIT_CKON = 0;
    localparam logic [4:0] MSK_RES_ONES = 5'h1f;
    localparam int CLK_PERIOD_NS = 100;
    typedef enum logic {ST_IDLE, ST_RAM} chic_state_t;
endpackage

/* File: chic_clk_if.sv */
// Clock controls and enables passed between the top and the clock generator.
`timescale 1ns/10ps
`default_nettype none
interface chic_clk_if;
    logic pll_run;
    logic osc_run;
    logic sys_halve;
    logic mem_halve;
    logic stall;
    logic [3:0] div;
    logic sclk_en;
    logic mclk_en;
    logic clkout;
    modport ctl (output pll_run, osc_run, sys_halve, mem_halve, stall, div,
                 input sclk_en, mclk_en, clkout);
    modport gen (input pll_run, osc_run, sys_halve, mem_halve, stall, div,
                 output sclk_en, mclk_en, clkout);
endinterface
`default_nettype wire

/* File: chic_clkgen.sv */
// Derives system, memory and clock-output enables from the doubled clock or the oscillator.
`timescale 1ns/10ps
`default_nettype none
module chic_clkgen #(
    parameter int DIV_W = 4
) (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Controls and enables
    chic_clk_if.gen c
);
    if (DIV_W != 4) $error("chic_clkgen: DIV_W must be 4");

    logic xph_r, xph_nxt, sph_r, sph_nxt, mph_r, mph_nxt;
    logic sen_r, sen_nxt, men_r, men_nxt, cko_r, cko_nxt;
    logic [DIV_W-1:0] cnt_r, cnt_nxt;
    logic pll_tick, osc_input_tick, src_tick;
    logic [DIV_W-1:0] lim;

    // Each core cycle with the doubler running is one doubled-clock tick.
    always_comb
    begin
        pll_tick = c.pll_run;
        // Outside power-down the oscillator phase keeps running while the doubler is stopped.
        osc_input_tick = c.osc_run & xph_r;
        src_tick = c.sys_halve ? osc_input_tick : pll_tick;
        lim = (c.div == 4'hf) ? 4'he : c.div;
        xph_nxt = c.osc_run ? ~xph_r : xph_r;
        sph_nxt = src_tick ? ~sph_r : sph_r;
        sen_nxt = src_tick & sph_r;
        mph_nxt = sen_nxt ? ~mph_r : mph_r;
        men_nxt = sen_nxt & (~c.mem_halve | mph_r);
        cnt_nxt = cnt_r;
        cko_nxt = cko_r;
        if (pll_tick && !c.stall)
        begin
            if (cnt_r >= lim)
            begin
                cnt_nxt = '0;
                cko_nxt = ~cko_r;
            end
            else
            begin
                cnt_nxt = cnt_r + 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            xph_r <= 1'b0;
            sph_r <= 1'b0;
            mph_r <= 1'b0;
            sen_r <= 1'b0;
            men_r <= 1'b0;
            cko_r <= 1'b0;
            cnt_r <= '0;
        end
        else
        begin
            xph_r <= xph_nxt;
            sph_r <= sph_nxt;
            mph_r <= mph_nxt;
            sen_r <= sen_nxt;
            men_r <= men_nxt;
            cko_r <= cko_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    assign c.sclk_en = sen_r;
    assign c.mclk_en = men_r;
    assign c.clkout = cko_r;
endmodule // chic_clkgen
`default_nettype wire

/* File: chic_mem_model.sv */
// Behavioural low-speed register memory that answers after a set delay.
`timescale 1ns/10ps
`default_nettype none
module chic_mem_model (
    // Clock and reset
    input wire logic i_core_clk,
    input wire logic i_reset_n,
    // Requests from the block and answer delay
    input wire logic i_req,
    input wire logic i_we,
    input wire logic i_word,
    input wire logic [7:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic [3:0] i_delay,
    // Answers to the block
    output logic o_ack,
    output logic [15:0] o_rdata
);
    logic [7:0] mem [256];
    logic [7:0] a;
    logic [15:0] dat;
    logic [3:0] cnt;
    logic we, wd, pend;
    // Outside an answer the data lines toggle, so stale data shows only on every second cycle.
    always @(posedge i_core_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            {o_ack, pend, o_rdata} <= {2'b00, 16'h5a5a};
        else
        begin
            o_ack <= 1'b0;
            o_rdata <= ~o_rdata;
            if (i_req)
                {pend, cnt, a, we, wd, dat} <=
                    {1'b1, i_delay, i_addr, i_we, i_word, i_wdata};
            else if (pend && cnt != 4'h0)
                cnt <= cnt - 4'h1;
            else if (pend)
            begin
                {pend, o_ack} <= 2'b01;
                o_rdata <= {mem[a + 8'h01], mem[a]};
                if (we)
                    mem[a] <= dat[7:0];
                if (we && wd)
                    mem[a + 8'h01] <= dat[15:8];
            end
        end
    end
endmodule // chic_mem_model
`default_nettype wire

/* File: test_chic_top.sv */
// Self-checking testbench for the host interface and clocking block.
`timescale 1ns/10ps
`default_nettype none
module test_chic_top
    import chic_pkg::*;
();
    logic i_core_clk, i_reset_n, i_host_rd, i_host_wr, i_host_word;
    logic o_host_rvalid, o_host_busy, o_host_wait, o_ram_req, o_ram_we;
    logic o_ram_word, i_ram_ack, o_sclk_en, o_mclk_en, o_pll_run, o_clkout;
    logic o_clkout_oe_n, o_mode_sleep, o_mode_pd, o_wakeup, i_can_activity;
    logic i_irq, i_p26_out, i_p26_oe_n, o_int_n, o_int_oe_n, o_p26;
    logic o_p26_oe_n, i_obj_xtd, i_remote_hit, o_std_match;
    logic [7:0] i_host_addr, o_ram_addr;
    logic [15:0] i_host_wdata, o_host_rdata, o_ram_wdata, i_ram_rdata, d;
    logic [3:0] i_clkout_divider, delay;
    logic [10:0] i_rx_id, i_obj_id, o_tx_id;
    int n_fail = 0;
    int num_checks = 0;
    int n_wake = 0;
    int str_mode = 0;
    chic_top dut (.i_core_clk, .i_reset_n, .i_host_addr, .i_host_rd,
        .i_host_wr, .i_host_word, .i_host_wdata, .o_host_rdata,
        .o_host_rvalid, .o_host_busy, .o_host_wait, .o_ram_req, .o_ram_we,
        .o_ram_word, .o_ram_addr, .o_ram_wdata, .i_ram_ack, .i_ram_rdata,
        .i_clkout_divider, .o_sclk_en, .o_mclk_en, .o_pll_run, .o_clkout,
        .o_clkout_oe_n, .o_mode_sleep, .o_mode_pd, .o_wakeup,
        .i_can_activity, .i_irq, .i_p26_out, .i_p26_oe_n, .o_int_n,
        .o_int_oe_n, .o_p26, .o_p26_oe_n, .i_rx_id, .i_obj_id, .i_obj_xtd,
        .i_remote_hit, .o_std_match, .o_tx_id);
    chic_mem_model mem (.i_core_clk, .i_reset_n, .i_req(o_ram_req),
        .i_we(o_ram_we), .i_word(o_ram_word), .i_addr(o_ram_addr),
        .i_wdata(o_ram_wdata), .i_delay(delay), .o_ack(i_ram_ack),
        .o_rdata(i_ram_rdata));
    initial
    begin
        i_core_clk = 1'b0;
        forever #50 i_core_clk = ~i_core_clk;
    end
    always @(posedge i_core_clk)
        if (o_wakeup === 1'b1)
            n_wake <= n_wake + 1;
    initial
    begin
        #3000000;
        n_fail++;
        give_verdict();
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    task automatic wait_n(input int n);
        repeat (n) @(posedge i_core_clk);
        #1;
    endtask
    // One host access; a read returns its data, a write waits until idle.
    task automatic acc(input logic rd, input logic [7:0] ad, input logic wd,
        input logic [15:0] wdat, output logic [15:0] rdat);
        int i;
        logic ck;
        @(posedge i_core_clk);
        {i_host_rd, i_host_wr, i_host_addr, i_host_word, i_host_wdata} <=
            {rd, ~rd, ad, wd, wdat};
        @(posedge i_core_clk);
        {i_host_rd, i_host_wr} <= 2'b00;
        for (i = 0; i < 40; i++)
        begin
            #1;
            if (i == 0)
                ck = o_clkout;
            if (o_host_busy === 1'b1 && str_mode != 0)
                chk(16'(o_host_wait), 16'(str_mode == 1));
            if (o_host_busy === 1'b1 && str_mode == 2)
                chk(16'(o_clkout), 16'(ck));
            if (rd ? o_host_rvalid === 1'b1 : o_host_busy === 1'b0)
                break;
            @(posedge i_core_clk);
        end
        if (i == 40)
            chk(16'h0, 16'h1);
        rdat = o_host_rdata;
    endtask
    task automatic do_reset();
        @(posedge i_core_clk);
        i_reset_n <= 1'b0;
        wait_n(20);
        chk(o_host_rdata, 16'h00e1);
        @(posedge i_core_clk);
        i_reset_n <= 1'b1;
        {i_host_wr, i_host_addr, i_host_word} <= {1'b1, OFS_MSK_LO, 1'b1};
        i_host_wdata <= 16'h0000;
        @(posedge i_core_clk);
        i_host_wr <= 1'b0;
        for (int i = 0; i < 8; i++)
        begin
            acc(1'b1, OFS_ICR, 1'b0, 16'h0, d);
            if (d[7] === 1'b0)
                break;
        end
        chk({8'h00, d[7:0]}, 16'h0061);
    endtask
    task automatic t_mask();
        logic [10:0] rx [4] = '{11'h2d5, 11'h2d5, 11'h6d5, 11'h2d7};
        acc(1'b0, OFS_MSK_LO, 1'b1, 16'h40a5, d);
        acc(1'b1, OFS_MSK_LO, 1'b1, 16'h0, d);
        chk(d, 16'h5fa5);
        acc(1'b1, OFS_MSK_HI, 1'b0, 16'h0, d);
        chk({8'h00, d[7:0]}, 16'h005f);
        for (int i = 0; i < 4; i++)
        begin
            @(posedge i_core_clk);
            {i_obj_xtd, i_rx_id} <= {i == 1, rx[i]};
            wait_n(2);
            chk(16'(o_std_match), 16'(i == 0));
        end
        @(posedge i_core_clk);
        {i_obj_id, i_remote_hit} <= {11'h155, 1'b1};
        @(posedge i_core_clk);
        i_remote_hit <= 1'b0;
        #1;
        chk(16'(o_tx_id), 16'h0155);
    endtask
    task automatic t_frb();
        acc(1'b0, 8'h10, 1'b1, 16'hbeef, d);
        acc(1'b0, 8'h12, 1'b1, 16'h1234, d);
        acc(1'b1, 8'h10, 1'b1, 16'h0, d);
        repeat (2) @(posedge i_core_clk);
        acc(1'b1, OFS_FRB_LO, 1'b1, 16'h0, d);
        chk(d, 16'hbeef);
        acc(1'b1, OFS_FRB_HI, 1'b0, 16'h0, d);
        chk({8'h00, d[7:0]}, 16'h00be);
        acc(1'b1, 8'h12, 1'b0, 16'h0, d);
        acc(1'b1, OFS_MSK_LO, 1'b1, 16'h0, d);
        acc(1'b1, OFS_FRB_LO, 1'b1, 16'h0, d);
        chk(d, 16'hbe34);
    endtask
    task automatic t_power();
        logic [7:0] v [4] = '{8'h61, 8'h69, 8'h71, 8'h79};
        logic [1:0] e [4] = '{2'b00, 2'b10, 2'b01, 2'b01};
        int w;
        w = n_wake;
        for (int i = 0; i < 4; i++)
        begin
            acc(1'b0, OFS_ICR, 1'b0, {8'h00, v[i]}, d);
            wait_n(3);
            chk(16'({o_mode_sleep, o_mode_pd}), 16'(e[i]));
            acc(1'b1, OFS_ICR, 1'b0, 16'h0, d);
            chk({8'h00, d[7:0]}, {8'h00, v[i]});
        end
        acc(1'b0, OFS_ICR, 1'b0, 16'h0069, d);
        wait_n(3);
        chk(16'(n_wake - w), 16'h2);
        @(posedge i_core_clk);
        i_can_activity <= 1'b1;
        repeat (8) @(posedge i_core_clk);
        i_can_activity <= 1'b0;
        wait_n(2);
        chk(16'({o_mode_sleep, n_wake - w == 3}), 16'h1);
        acc(1'b1, OFS_ICR, 1'b0, 16'h0, d);
        chk({8'h00, d[7:0]}, 16'h0061);
    endtask
    task automatic t_irq();
        logic [15:0] e;
        for (int m = 0; m < 2; m++)
            for (int q = 0; q < 2; q++)
            begin
                acc(1'b0, OFS_ICR, 1'b0, (m == 1) ? 16'h65 : 16'h61, d);
                @(posedge i_core_clk);
                {i_irq, i_p26_out, i_p26_oe_n} <= {q[0], q[0], ~q[0]};
                wait_n(3);
                e = (m == 1) ? {14'h0001, ~q[0], 1'b0} :
                    {12'h000, 1'b0, ~q[0], q[0], ~q[0]};
                if (m == 1)
                    chk(16'({o_int_oe_n, o_p26, o_p26_oe_n}), e);
                else
                    chk(16'({o_int_oe_n, o_int_n, o_p26, o_p26_oe_n}), e);
            end
    endtask
    task automatic t_clk();
        logic [7:0] v [4] = '{8'h01, 8'h21, 8'h41, 8'h61};
        int es [4] = '{20, 20, 10, 10};
        int em [4] = '{20, 10, 10, 5};
        int ns, nm, nc;
        logic p;
        for (int i = 0; i < 4; i++)
        begin
            acc(1'b0, OFS_ICR, 1'b0, {8'h00, v[i]}, d);
            {ns, nm} = 64'h0;
            nc = 0;
            wait_n(4);
            p = o_clkout;
            repeat (120)
            begin
                wait_n(1);
                ns += (o_sclk_en === 1'b1 && ns + nm < 999) ? 1 : 0;
                nm += (o_clkout !== p) ? 1 : 0;
                nc += (o_mclk_en === 1'b1) ? 1 : 0;
                p = o_clkout;
            end
            chk(16'(ns), 16'(es[i] * 3));
            chk(16'(nm), 16'(120 / (i + 1)));
            chk(16'(nc), 16'(em[i] * 3));
            @(posedge i_core_clk);
            i_clkout_divider <= 4'(i + 1);
        end
        nm = 0;
        repeat (40)
        begin
            wait_n(1);
            nm += (o_mclk_en === 1'b1) ? 1 : 0;
        end
        chk(16'(nm), 16'(em[3]));
        acc(1'b0, OFS_ICR, 1'b0, 16'h0060, d);
        wait_n(3);
        chk(16'(o_clkout_oe_n), 16'h1);
        acc(1'b0, OFS_ICR, 1'b0, 16'h0042, d);
        wait_n(3);
        chk(16'(o_pll_run), 16'h0);
        ns = 0;
        repeat (40)
        begin
            wait_n(1);
            ns += (o_sclk_en === 1'b1) ? 1 : 0;
        end
        chk(16'(ns), 16'h000a);
    endtask
    task automatic t_stretch();
        delay <= 4'h6;
        acc(1'b0, OFS_ICR, 1'b0, 16'h0063, d);
        str_mode = 2;
        acc(1'b1, 8'h10, 1'b1, 16'h0, d);
        chk(d, 16'hbeef);
        acc(1'b0, OFS_ICR, 1'b0, 16'h0061, d);
        str_mode = 1;
        acc(1'b1, 8'h10, 1'b1, 16'h0, d);
        str_mode = 0;
        chk(16'({o_pll_run, o_clkout_oe_n}), 16'h2);
    endtask
    initial
    begin
        {i_host_rd, i_host_wr, i_host_word, i_can_activity} = 4'h0;
        {i_irq, i_p26_out, i_obj_xtd, i_remote_hit, i_reset_n} = 5'h0;
        {i_host_addr, i_host_wdata, i_rx_id, i_obj_id} = '0;
        {i_clkout_divider, delay, i_p26_oe_n} = 9'h1;
        do_reset();
        t_mask();
        t_frb();
        t_power();
        t_irq();
        t_clk();
        t_stretch();
        do_reset();
        acc(1'b1, OFS_MSK_LO, 1'b1, 16'h0, d);
        chk(d, 16'h5fa5);
        acc(1'b1, OFS_FRB_LO, 1'b1, 16'h0, d);
        chk(d, 16'hbeef);
        give_verdict();
    end
endmodule // test_chic_top
`default_nettype wire
